/* File: atle_pkg.sv */
// Purpose: Shared constants for the arithmetic, table and load executor
// Assumes: 10-bit instruction words, 4-bit data path
// Notes: Add patterns are matched under MSK_FULL or MSK_NIB, the others under the mask beside them
package atle_pkg;
    localparam int INST_W = 10;
    localparam int NIB_W = 4;
    localparam int PAGE_W = 6;
    localparam int TPAGE_W = 3;
    localparam int ROM_ADDR_W = 13;
    // Opcode patterns and masks
    localparam logic [9:0] OP_LOAD_IMM = 10'h070;
    localparam logic [9:0] MSK_NIB = 10'h3F0;
    localparam logic [9:0] OP_TABLE_LOOKUP = 10'h080;
    localparam logic [9:0] MSK_TABLE = 10'h3C0;
    localparam logic [9:0] OP_ADD_MEMORY = 10'h00A;
    localparam logic [9:0] OP_ADD_MEMORY_CARRY = 10'h00B;
    localparam logic [9:0] OP_ADD_IMM = 10'h060;
    localparam logic [9:0] OP_BIT_CLEAR = 10'h04C;
    localparam logic [9:0] OP_SKIP_BIT_ZERO = 10'h020;
    localparam logic [9:0] MSK_BIT = 10'h3FC;
    localparam logic [9:0] OP_SKIP_EQUAL_MEMORY = 10'h026;
    localparam logic [9:0] OP_SKIP_EQUAL_IMM = 10'h025;
    localparam logic [9:0] MSK_FULL = 10'h3FF;
    // Field positions
    localparam int NIB_LSB = 0;
    localparam int BHI_LSB = 4;
    localparam int DHI_LSB = 8;
    // Reset values
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] BREG_RST = 4'h0;
    localparam logic [2:0] TPAGE_RST = 3'h0;
    localparam logic CARRY_RST = 1'b0;
    // Table lookup sequencer
    typedef enum logic [1:0] {
        ATLE_IDLE = 2'b00,
        ATLE_WAIT = 2'b01,
        ATLE_DONE = 2'b11
    } atle_state_e;
endpackage

/* File: atle_exec.sv */
// Purpose: Executes load, table lookup, add, bit clear and skip instructions
// Assumes: Decode, RAM read data and ROM answer arrive on sys_clk, same cycle as valid
// Notes: Skipped instruction is consumed here; skipNextQ also informs fetch
`timescale 1ns/100ps

// Contract
// - A load-immediate writes its 4-bit operand into the accumulator.
// - In a run of back-to-back load-immediates only the first executes, the rest are skipped.
// - Table lookup with the upper flag clear puts word bits 7-4 in B and 3-0 in the accumulator.
// - Table lookup with the upper flag set also loads word bits 9-8 into the table page register.
// - Table address is the operand page followed by three table page bits and the accumulator.
// - Table lookup uses one return stack level while it runs.
// - Add-memory adds the addressed nibble to the accumulator and keeps the carry.
// - Add-memory-carry adds nibble and carry, storing sum and carry-out.
// - Add-immediate adds its operand to the accumulator and keeps the carry.
// - Add-immediate skips the next instruction when no overflow occurred.
// - Bit clear zeroes the selected bit of the addressed nibble, keeping the others.
// - Skip-bit-zero skips the next instruction when the selected bit is zero.
// - Skip-equal-memory skips the next instruction when accumulator equals the nibble.
module atle_exec
    import atle_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic instValid,
    input wire logic [INST_W-1:0] instWord,
    input wire logic [INST_W-1:0] instWord2,
    input wire logic [NIB_W-1:0] memData,
    input wire logic upperTableFlag,
    input wire logic romValid,
    input wire logic [INST_W-1:0] romData,
    output logic [NIB_W-1:0] accQ,
    output logic [NIB_W-1:0] bRegQ,
    output logic [TPAGE_W-1:0] tablePageQ,
    output logic carryQ,
    output logic skipNextQ,
    output logic busyQ,
    output logic memWrEnQ,
    output logic [NIB_W-1:0] memWrDataQ,
    output logic romReqQ,
    output logic [ROM_ADDR_W-1:0] romAddrQ,
    output logic stackPushQ,
    output logic stackPopQ
);
    // Masked opcode match
    function automatic logic opIs(input logic [9:0] w, input logic [9:0] p, input logic [9:0] m);
        return (w & m) == p;
    endfunction

    atle_state_e stateQ, stateD;
    logic skipArmQ;
    logic prevLoadQ;
    logic uptfQ;

    // Decode of the presented instruction
    wire take = instValid && (stateQ == ATLE_IDLE);
    wire live = take && !skipArmQ;
    wire isLoad = opIs(instWord, OP_LOAD_IMM, MSK_NIB);
    wire isTable = opIs(instWord, OP_TABLE_LOOKUP, MSK_TABLE);
    wire isAddMem = opIs(instWord, OP_ADD_MEMORY, MSK_FULL);
    wire isAddMemC = opIs(instWord, OP_ADD_MEMORY_CARRY, MSK_FULL);
    wire isAddImm = opIs(instWord, OP_ADD_IMM, MSK_NIB);
    wire isBitClr = opIs(instWord, OP_BIT_CLEAR, MSK_BIT);
    wire isSkipBit = opIs(instWord, OP_SKIP_BIT_ZERO, MSK_BIT);
    wire isSkipMem = opIs(instWord, OP_SKIP_EQUAL_MEMORY, MSK_FULL);
    wire isSkipImm = opIs(instWord, OP_SKIP_EQUAL_IMM, MSK_FULL);
    wire [NIB_W-1:0] imm = instWord[NIB_LSB +: NIB_W];
    wire [1:0] bitSel = instWord[1:0];
    wire [NIB_W-1:0] bitMask = 4'h1 << bitSel;

    // Adders, five bits wide for carry and overflow
    wire [NIB_W:0] sumMem = {1'b0, accQ} + {1'b0, memData};
    wire [NIB_W:0] sumMemC = sumMem + {4'h0, carryQ};
    wire [NIB_W:0] sumImm = {1'b0, accQ} + {1'b0, imm};
    wire memBitZero = (memData & bitMask) == 4'h0;
    wire loadRun = isLoad && prevLoadQ;

    // Skip decision for the next instruction
    wire skipReq = live && ((isAddImm && !sumImm[NIB_W]) || (isSkipBit && memBitZero)
        || (isSkipMem && accQ == memData) || (isSkipImm && accQ == instWord2[NIB_W-1:0]));
    wire romDone = (stateQ == ATLE_WAIT) && romValid;

    // Table lookup sequencer
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            ATLE_IDLE: begin
                if (live && isTable) begin
                    stateD = ATLE_WAIT;
                end
            end
            ATLE_WAIT: begin
                if (romValid) begin
                    stateD = ATLE_DONE;
                end
            end
            ATLE_DONE: stateD = ATLE_IDLE;
            default: stateD = ATLE_IDLE;
        endcase
    end

    // Sequencer and control flags
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stateQ <= ATLE_IDLE;
            skipArmQ <= 1'b0;
            prevLoadQ <= 1'b0;
            uptfQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            if (take) begin
                skipArmQ <= skipReq;
                prevLoadQ <= isLoad;
            end
            if (live && isTable) begin
                uptfQ <= upperTableFlag;
            end
        end
    end

    // Accumulator: load, table low nibble and sums
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            accQ <= ACC_RST;
        end else if (romDone) begin
            accQ <= romData[NIB_LSB +: NIB_W];
        end else if (live) begin
            if (isLoad && !loadRun) begin
                accQ <= imm;
            end else if (isAddMem) begin
                accQ <= sumMem[NIB_W-1:0];
            end else if (isAddMemC) begin
                accQ <= sumMemC[NIB_W-1:0];
            end else if (isAddImm) begin
                accQ <= sumImm[NIB_W-1:0];
            end
        end
    end

    // Carry flag, changed only by add with carry
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            carryQ <= CARRY_RST;
        end else if (live && isAddMemC) begin
            carryQ <= sumMemC[NIB_W];
        end
    end

    // B and table page from the fetched word
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bRegQ <= BREG_RST;
            tablePageQ <= TPAGE_RST;
        end else if (romDone) begin
            bRegQ <= romData[BHI_LSB +: NIB_W];
            if (uptfQ) begin
                tablePageQ <= {1'b0, romData[DHI_LSB +: 2]};
            end
        end
    end

    // ROM request, stack and RAM write strobes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            romReqQ <= 1'b0;
            romAddrQ <= '0;
            stackPushQ <= 1'b0;
            stackPopQ <= 1'b0;
            memWrEnQ <= 1'b0;
            memWrDataQ <= 4'h0;
            skipNextQ <= 1'b0;
        end else begin
            romReqQ <= live && isTable;
            stackPushQ <= live && isTable;
            stackPopQ <= romDone;
            if (live && isTable) begin
                romAddrQ <= {instWord[PAGE_W-1:0], tablePageQ, accQ};
            end
            memWrEnQ <= live && isBitClr;
            memWrDataQ <= memData & ~bitMask;
            skipNextQ <= skipReq || (take && loadRun);
        end
    end

    // Busy while a table lookup is in flight
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busyQ <= 1'b0;
        end else begin
            busyQ <= (stateD != ATLE_IDLE);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_LOAD_IMM: assert property (live && isLoad && !loadRun |=> accQ == $past(imm))
        else $error("load immediate not written");
    AST_LOAD_RUN: assert property (live && loadRun |=> accQ == $past(accQ) && skipNextQ)
        else $error("consecutive load not skipped");
    AST_TBL_LOW: assert property (romDone |=> bRegQ == $past(romData[7:4])
        && accQ == $past(romData[3:0]))
        else $error("table nibbles wrong");
    AST_TBL_PAGE: assert property (romDone && uptfQ |=>
        tablePageQ == {1'b0, $past(romData[9:8])})
        else $error("table page not loaded");
    AST_TBL_ADDR: assert property (live && isTable |=> romReqQ
        && romAddrQ == {$past(instWord[5:0]), $past(tablePageQ), $past(accQ)})
        else $error("table address wrong");
    AST_STACK: assert property (live && isTable |=> stackPushQ ##1 (!stackPushQ && busyQ))
        else $error("stack level not taken");
    AST_ADD_MEM: assert property (live && isAddMem |=> accQ == $past(sumMem[3:0])
        && $stable(carryQ))
        else $error("add memory wrong");
    AST_ADD_CARRY: assert property (live && isAddMemC |=> {carryQ, accQ}
        == ({1'b0, $past(accQ)} + {1'b0, $past(memData)} + {4'h0, $past(carryQ)}))
        else $error("add with carry wrong");
    AST_ADD_IMM: assert property (live && isAddImm |=> $stable(carryQ)
        && accQ == $past(sumImm[3:0]))
        else $error("add immediate wrong");
    AST_ADD_SKIP: assert property (live && isAddImm |=> skipNextQ == !$past(sumImm[4]))
        else $error("add immediate skip wrong");
    AST_BIT_CLR: assert property (live && isBitClr |=> memWrEnQ
        && memWrDataQ == ($past(memData) & ~(4'h1 << $past(bitSel))))
        else $error("bit clear wrong");
    AST_BIT_SKIP: assert property (live && isSkipBit |=> skipNextQ == $past(memBitZero))
        else $error("bit skip wrong");
    AST_CMP_MEM: assert property (live && isSkipMem |=> skipNextQ == ($past(accQ)
        == $past(memData)))
        else $error("compare memory skip wrong");
    AST_CMP_IMM: assert property (live && isSkipImm |=> skipNextQ == ($past(accQ)
        == $past(instWord2[3:0])))
        else $error("compare immediate skip wrong");
    AST_WRAP: assert property (live && isAddMem && sumMem[4] |=> accQ < $past(accQ))
        else $error("sum did not wrap");

    COV_TABLE: cover property (live && isTable ##[1:20] romDone);
    COV_LOAD_RUN: cover property (live && isLoad ##1 live && isLoad);
    COV_ADD_SKIP: cover property (live && isAddImm && !sumImm[4]);
    COV_CARRY_OUT: cover property (live && isAddMemC && sumMemC[4]);
endmodule

/* File: atle_rom_model.sv */
// Purpose: Program ROM and stack depth model facing the executor
// Assumes: One read in flight, answered after romDelay extra cycles
// Notes: Word at an address is its low ten bits XOR 35A
`timescale 1ns/100ps
module atle_rom_model
    import atle_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [3:0] romDelay,
    input wire logic romReqQ,
    input wire logic [ROM_ADDR_W-1:0] romAddrQ,
    input wire logic stackPushQ,
    input wire logic stackPopQ,
    output logic romValid,
    output logic [INST_W-1:0] romData,
    output logic [3:0] stackDepth
);
    logic [ROM_ADDR_W-1:0] addr;
    logic [4:0] cnt;
    logic [INST_W-1:0] last;
    // Read latency, answer pulse and stack level count
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h00;
            romValid <= 1'b0;
            last <= 10'h155;
            romData <= 10'h155;
            stackDepth <= 4'h0;
        end else begin
            romValid <= 1'b0;
            romData <= ~last; // No stale word between answers
            stackDepth <= stackDepth + {3'h0, stackPushQ} - {3'h0, stackPopQ};
            if (romReqQ) begin
                addr <= romAddrQ;
                cnt <= {1'b0, romDelay} + 5'h01;
            end else if (cnt == 5'h01) begin
                romValid <= 1'b1;
                romData <= addr[9:0] ^ 10'h35A;
                last <= addr[9:0] ^ 10'h35A;
                cnt <= 5'h00;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

/* File: arith_table_load_exec_test.sv */
// Purpose: Self-checking bench for the executor
// Assumes: Answers show 1 ns after the taking edge
// Notes: Expected values tracked in expAcc and expTp
`timescale 1ns/100ps
module arith_table_load_exec_test;
    import atle_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic instValid = 1'b0;
    logic upperTableFlag = 1'b0;
    logic [9:0] instWord = 10'h000;
    logic [9:0] instWord2 = 10'h000;
    logic [3:0] memData = 4'h0;
    logic [3:0] romDelay = 4'h0;
    logic [3:0] expAcc = 4'h0;
    logic [2:0] expTp = 3'h0;
    logic lastSkip;
    int miscompares = 0;
    int checkCount = 0;
    wire logic romValid, carryQ, skipNextQ, busyQ, memWrEnQ, romReqQ, stackPushQ, stackPopQ;
    wire logic [9:0] romData;
    wire logic [3:0] accQ, bRegQ, memWrDataQ, stackDepth;
    wire logic [2:0] tablePageQ;
    wire logic [12:0] romAddrQ;
    // Clock, 4 ns period
    always #2 sys_clk = ~sys_clk;
    atle_exec atle_exec_i (.sys_clk(sys_clk), .resetn(resetn), .instValid(instValid),
        .instWord(instWord), .instWord2(instWord2), .memData(memData),
        .upperTableFlag(upperTableFlag), .romValid(romValid), .romData(romData),
        .accQ(accQ), .bRegQ(bRegQ), .tablePageQ(tablePageQ), .carryQ(carryQ),
        .skipNextQ(skipNextQ), .busyQ(busyQ), .memWrEnQ(memWrEnQ), .memWrDataQ(memWrDataQ),
        .romReqQ(romReqQ), .romAddrQ(romAddrQ), .stackPushQ(stackPushQ), .stackPopQ(stackPopQ));
    atle_rom_model atle_rom_model_i (.sys_clk(sys_clk), .resetn(resetn), .romDelay(romDelay),
        .romReqQ(romReqQ), .romAddrQ(romAddrQ), .stackPushQ(stackPushQ),
        .stackPopQ(stackPopQ), .romValid(romValid), .romData(romData), .stackDepth(stackDepth));
    task automatic final_report;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One instruction, outputs settled on return
    task automatic issue(input logic [9:0] w, input logic [3:0] m, input logic [9:0] w2);
        @(posedge sys_clk);
        instValid <= 1'b1;
        instWord <= w;
        instWord2 <= w2;
        memData <= m;
        @(posedge sys_clk);
        instValid <= 1'b0;
        memData <= ~m; // RAM nibble not held past its cycle
        #1;
    endtask
    // Skip decision, then a harmless filler for the slot
    task automatic skip_seen(input logic [9:0] w, input logic [3:0] m, input logic [9:0] w2);
        issue(w, m, w2);
        lastSkip = skipNextQ;
        issue(OP_ADD_MEMORY, 4'h0, 10'h000);
    endtask
    task automatic test_load;
        @(posedge sys_clk);
        instValid <= 1'b1;
        instWord <= OP_LOAD_IMM | 10'h005;
        @(posedge sys_clk);
        instWord <= OP_LOAD_IMM | 10'h009;
        @(posedge sys_clk);
        instValid <= 1'b0;
        #1;
        chk(accQ, 4'h5);
        chk(skipNextQ, 1'b1);
        issue(OP_ADD_MEMORY, 4'h0, 10'h000);
        $display("load test done");
    endtask
    task automatic test_add;
        issue(OP_LOAD_IMM | 10'h009, 4'h0, 10'h000);
        issue(OP_ADD_MEMORY_CARRY, 4'hF, 10'h000);
        chk({carryQ, accQ}, 5'h18);
        issue(OP_ADD_MEMORY, 4'h9, 10'h000);
        chk({carryQ, accQ}, 5'h11);
        issue(OP_ADD_IMM | 10'h003, 4'h0, 10'h000);
        chk({skipNextQ, carryQ, accQ}, 6'h34);
        issue(OP_ADD_MEMORY, 4'hF, 10'h000);
        chk(accQ, 4'h4);
        issue(OP_ADD_IMM | 10'h00F, 4'h0, 10'h000);
        chk({skipNextQ, carryQ, accQ}, 6'h13);
        expAcc = 4'h3;
        $display("add test done");
    endtask
    task automatic test_bits;
        for (int j = 0; j < 4; j++) begin
            issue(OP_BIT_CLEAR | 10'(j), 4'hF, 10'h000);
            chk({memWrEnQ, memWrDataQ}, {1'b1, 4'hF & ~(4'h1 << j)});
            skip_seen(OP_SKIP_BIT_ZERO | 10'(j), ~(4'h1 << j), 10'h000);
            chk(lastSkip, 1'b1);
            skip_seen(OP_SKIP_BIT_ZERO | 10'(j), 4'h1 << j, 10'h000);
            chk(lastSkip, 1'b0);
        end
        skip_seen(OP_SKIP_EQUAL_MEMORY, 4'h3, 10'h000);
        chk(lastSkip, 1'b1);
        skip_seen(OP_SKIP_EQUAL_MEMORY, 4'h4, 10'h000);
        chk(lastSkip, 1'b0);
        skip_seen(OP_SKIP_EQUAL_IMM, 4'h0, 10'h003);
        chk(lastSkip, 1'b1);
        skip_seen(OP_SKIP_EQUAL_IMM, 4'h0, 10'h00C);
        chk(lastSkip, 1'b0);
        $display("bit and skip test done");
    endtask
    task automatic test_table(input logic [5:0] p, input logic flag, input logic [3:0] dly);
        logic [12:0] addr;
        logic [9:0] word;
        int n;
        addr = {p, expTp, expAcc};
        word = addr[9:0] ^ 10'h35A;
        @(posedge sys_clk);
        romDelay <= dly;
        upperTableFlag <= flag;
        issue(OP_TABLE_LOOKUP | {4'h0, p}, 4'h0, 10'h000);
        chk({romReqQ, stackPushQ, busyQ, romAddrQ}, {3'b111, addr});
        n = 0;
        while (stackPopQ !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n == 1) chk(stackDepth, 4'h1);
        end
        if (stackPopQ !== 1'b1) begin
            miscompares++;
            final_report();
        end
        expAcc = word[3:0];
        if (flag) expTp = {1'b0, word[9:8]};
        chk({bRegQ, accQ, 1'b0, tablePageQ}, {word[7:4], word[3:0], 1'b0, expTp});
        @(posedge sys_clk);
        #1;
        chk(stackDepth, 4'h0);
        $display("table test done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk({accQ, bRegQ, carryQ, busyQ}, 10'h000);
        test_load();
        test_add();
        test_bits();
        test_table(6'h15, 1'b0, 4'h0);
        test_table(6'h2A, 1'b1, 4'h3);
        test_table(6'h07, 1'b0, 4'h1);
        final_report();
    end
endmodule
